// >>> logic/adc_seq_consts.svh
`ifndef ADC_SEQ_CONSTS_SVH
`define ADC_SEQ_CONSTS_SVH

// System clock period
`define SYS_CLK_NS          20

// Conversion length, internal oscillator
`define CONV_TIME_MS        147
`define CONV_CYC            ((`CONV_TIME_MS * 1000000) / `SYS_CLK_NS)

// Conversion length in external conversion clock periods
`define EXT_CONV_PERIODS    20510

// Longest data output state, internal oscillator and internal SCK
`define DOUT_MAX_NS         1090000
`define DOUT_OSC_PERIODS    152
`define OSC_CYC             ((`DOUT_MAX_NS / `SYS_CLK_NS) / `DOUT_OSC_PERIODS)

// Internal SCK is the conversion clock divided by this
`define SCK_DIV             8

// Lowest external conversion clock that counts as present
`define EXT_DET_HZ          2560
`define EXT_DET_CYC         (1000000000 / (`EXT_DET_HZ * `SYS_CLK_NS))

// Output frame layout
`define FRAME_BITS          19
`define FRAME_EOC_POS       18
`define FRAME_DUMMY_POS     17
`define FRAME_SIGN_POS      16
`define FRAME_LAST_FALL     18

`endif

// >>> logic/adc_seq_pkg.sv
package adc_seq_pkg;

    typedef enum logic [1:0] {
        ST_CONVERT,
        ST_SLEEP,
        ST_DOUT
    } seq_state_t;

endpackage

// >>> logic/tick_divider.sv
`timescale 1ns/1ns
`default_nettype none

module tick_divider #(
    parameter int DIV = 8
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic reset_n,
    // Count control
    input  wire logic enable,
    input  wire logic restart,
    // One cycle every DIV enabled cycles
    output logic      tick
);

    localparam int W = (DIV > 2) ? $clog2(DIV) : 1;

    generate
        if (DIV < 2) begin : g_bad_div
            $error("tick_divider needs DIV of at least 2");
        end
    endgenerate

    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    logic         tick_reg;
    logic         tick_next;

    always_comb begin
        cnt_next  = cnt_reg;
        tick_next = 1'b0;
        if (restart) begin
            cnt_next = '0;
        end else if (enable) begin
            if (cnt_reg == W'(DIV - 1)) begin
                cnt_next  = '0;
                tick_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            cnt_reg  <= '0;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg;

endmodule // tick_divider

`default_nettype wire

// >>> logic/adc_serial_readout_sequencer.sv
`include "adc_seq_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module adc_serial_readout_sequencer #(
    parameter int CONV_CYC    = `CONV_CYC,
    parameter int EXT_DET_CYC = `EXT_DET_CYC,
    parameter int OSC_CYC     = `OSC_CYC
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    // Serial port
    input  wire logic        cs_n,
    input  wire logic        sck_in,
    output logic             sck_out,
    output logic             sck_oe,
    output logic             sdo_out,
    output logic             sdo_oe,
    // Conversion clock source pin
    input  wire logic        conv_clock_select_pin,
    // Result from the filter
    input  wire logic [15:0] result_data,
    input  wire logic        result_sign,
    // Status to the converter core
    output logic             conv_start,
    output logic             conv_busy,
    output logic             ext_sck_mode,
    output logic             ext_osc_active
);

    localparam int CW = 23;
    localparam int DW = 16;

    generate
        if (CONV_CYC < 2 || CONV_CYC >= (1 << CW)) begin : g_bad_conv
            $error("CONV_CYC out of range for the conversion counter");
        end
        if (EXT_DET_CYC < 2 || EXT_DET_CYC >= (1 << DW)) begin : g_bad_det
            $error("EXT_DET_CYC out of range for the detect counter");
        end
    endgenerate

    adc_seq_pkg::seq_state_t state_reg;
    adc_seq_pkg::seq_state_t state_next;

    logic [CW-1:0]            conv_cnt_reg;
    logic [CW-1:0]            conv_cnt_next;
    logic [4:0]               bit_cnt_reg;
    logic [4:0]               bit_cnt_next;
    logic [`FRAME_BITS-1:0]   shift_reg;
    logic [`FRAME_BITS-1:0]   shift_next;
    logic                     sck_lvl_reg;
    logic                     sck_lvl_next;
    logic                     ext_mode_reg;
    logic                     ext_mode_next;
    logic                     por_pending_reg;
    logic                     conv_start_reg;
    logic                     conv_start_next;
    logic                     cs_q_reg;
    logic                     sck_q_reg;
    logic                     osc_pin_q_reg;
    logic [DW-1:0]            det_cnt_reg;
    logic [DW-1:0]            det_cnt_next;
    logic                     sdo_out_reg;
    logic                     sdo_out_next;
    logic                     sdo_oe_reg;
    logic                     sck_out_reg;
    logic                     sck_oe_reg;
    logic                     busy_reg;
    // Flopped copy of the detect compare so the status output is a register
    logic                     ext_active_reg;

    logic                     cs_fall;
    logic                     cs_rise;
    logic                     sck_rise_ext;
    logic                     sck_fall_ext;
    logic                     ext_rise;
    logic                     ext_present;
    logic                     osc_tick;
    logic                     conv_tick;
    logic                     conv_step;
    logic [CW-1:0]            conv_last;
    logic                     half_run;
    logic                     half_tick;

    assign cs_fall      = cs_q_reg & ~cs_n;
    assign cs_rise      = ~cs_q_reg & cs_n;
    assign sck_rise_ext = sck_in & ~sck_q_reg;
    assign sck_fall_ext = ~sck_in & sck_q_reg;
    assign ext_rise     = conv_clock_select_pin & ~osc_pin_q_reg;

    // A pin held low or too slow falls back to the internal oscillator
    assign ext_present = (det_cnt_reg < DW'(EXT_DET_CYC));

    always_comb begin
        det_cnt_next = det_cnt_reg;
        if (ext_rise) begin
            det_cnt_next = '0;
        end else if (!ext_present) begin
            det_cnt_next = det_cnt_reg;
        end else begin
            det_cnt_next = det_cnt_reg + 1'b1;
        end
    end

    // Internal oscillator period
    tick_divider #(
        .DIV (OSC_CYC)
    ) u_osc_div (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .enable  (1'b1),
        .restart (1'b0),
        .tick    (osc_tick)
    );

    assign conv_tick = ext_present ? ext_rise : osc_tick;

    // Half period of the internal SCK; runs only while it may toggle
    assign half_run = ~cs_n & ~ext_mode_reg
                    & ((state_reg == adc_seq_pkg::ST_SLEEP) | (state_reg == adc_seq_pkg::ST_DOUT));

    tick_divider #(
        .DIV (`SCK_DIV / 2)
    ) u_sck_div (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .enable  (half_run & conv_tick),
        .restart (~half_run),
        .tick    (half_tick)
    );

    // Internal oscillator counts system cycles for the exact length
    assign conv_step = ext_present ? ext_rise : 1'b1;
    assign conv_last = ext_present ? CW'(`EXT_CONV_PERIODS - 1)
                                   : CW'(CONV_CYC - 1);

    always_comb begin
        state_next      = state_reg;
        conv_cnt_next   = conv_cnt_reg;
        bit_cnt_next    = bit_cnt_reg;
        shift_next      = shift_reg;
        sck_lvl_next    = sck_lvl_reg;
        conv_start_next = por_pending_reg;
        ext_mode_next   = ext_mode_reg;

        if (por_pending_reg) begin
            ext_mode_next = ~sck_in;
        end else if (cs_fall) begin
            ext_mode_next = ~sck_in;
        end

        case (state_reg)
            adc_seq_pkg::ST_CONVERT: begin
                // SCK held high and extra host clocks ignored while converting
                sck_lvl_next = 1'b1;
                if (conv_step) begin
                    if (conv_cnt_reg == conv_last) begin
                        state_next    = adc_seq_pkg::ST_SLEEP;
                        conv_cnt_next = '0;
                        shift_next    = {1'b0, 1'b0, result_sign, result_data};
                    end else begin
                        conv_cnt_next = conv_cnt_reg + 1'b1;
                    end
                end
            end

            adc_seq_pkg::ST_SLEEP: begin
                bit_cnt_next = '0;
                if (cs_n) begin
                    sck_lvl_next = 1'b1;
                end else if (ext_mode_reg) begin
                    if (sck_rise_ext) begin
                        state_next = adc_seq_pkg::ST_DOUT;
                    end
                end else if (!sck_lvl_reg && half_tick) begin
                    sck_lvl_next = 1'b1;
                    state_next   = adc_seq_pkg::ST_DOUT;
                end else begin
                    sck_lvl_next = 1'b0;
                end
            end

            adc_seq_pkg::ST_DOUT: begin
                if (cs_rise) begin
                    state_next      = adc_seq_pkg::ST_CONVERT;
                    conv_cnt_next   = '0;
                    conv_start_next = 1'b1;
                    sck_lvl_next    = 1'b1;
                end else if (ext_mode_reg) begin
                    if (sck_fall_ext) begin
                        if (bit_cnt_reg == 5'(`FRAME_LAST_FALL)) begin
                            state_next      = adc_seq_pkg::ST_CONVERT;
                            conv_cnt_next   = '0;
                            conv_start_next = 1'b1;
                        end else begin
                            shift_next   = {shift_reg[`FRAME_BITS-2:0], 1'b0};
                            bit_cnt_next = bit_cnt_reg + 1'b1;
                        end
                    end
                end else if (half_tick) begin
                    if (sck_lvl_reg) begin
                        sck_lvl_next = 1'b0;
                        shift_next   = {shift_reg[`FRAME_BITS-2:0], 1'b0};
                        bit_cnt_next = bit_cnt_reg + 1'b1;
                    end else begin
                        sck_lvl_next = 1'b1;
                        // Last rising edge ends the frame, SCK stays high
                        if (bit_cnt_reg == 5'(`FRAME_LAST_FALL)) begin
                            state_next      = adc_seq_pkg::ST_CONVERT;
                            conv_cnt_next   = '0;
                            conv_start_next = 1'b1;
                        end
                    end
                end
            end

            default: begin
                state_next    = adc_seq_pkg::ST_CONVERT;
                conv_cnt_next = '0;
            end
        endcase
    end

    // Data line shows the frame in output, else the flag
    always_comb begin
        if (state_next == adc_seq_pkg::ST_DOUT) begin
            sdo_out_next = shift_next[`FRAME_EOC_POS];
        end else begin
            sdo_out_next = (state_next == adc_seq_pkg::ST_CONVERT);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state_reg       <= adc_seq_pkg::ST_CONVERT;
            conv_cnt_reg    <= '0;
            bit_cnt_reg     <= '0;
            shift_reg       <= '0;
            sck_lvl_reg     <= 1'b1;
            ext_mode_reg    <= 1'b0;
            por_pending_reg <= 1'b1;
            conv_start_reg  <= 1'b0;
            cs_q_reg        <= 1'b1;
            sck_q_reg       <= 1'b1;
            osc_pin_q_reg   <= 1'b0;
            det_cnt_reg     <= DW'(EXT_DET_CYC);
            sdo_out_reg     <= 1'b1;
            sdo_oe_reg      <= 1'b0;
            sck_out_reg     <= 1'b1;
            sck_oe_reg      <= 1'b0;
            busy_reg        <= 1'b1;
            ext_active_reg  <= 1'b0;
        end else begin
            state_reg       <= state_next;
            conv_cnt_reg    <= conv_cnt_next;
            bit_cnt_reg     <= bit_cnt_next;
            shift_reg       <= shift_next;
            sck_lvl_reg     <= sck_lvl_next;
            ext_mode_reg    <= ext_mode_next;
            por_pending_reg <= 1'b0;
            conv_start_reg  <= conv_start_next;
            cs_q_reg        <= cs_n;
            sck_q_reg       <= sck_in;
            osc_pin_q_reg   <= conv_clock_select_pin;
            det_cnt_reg     <= det_cnt_next;
            sdo_out_reg     <= sdo_out_next;
            sdo_oe_reg      <= ~cs_n;
            sck_out_reg     <= sck_lvl_next;
            sck_oe_reg      <= ~cs_n & ~ext_mode_next;
            busy_reg        <= (state_next == adc_seq_pkg::ST_CONVERT);
            ext_active_reg  <= (det_cnt_next < DW'(EXT_DET_CYC));
        end
    end

    assign sdo_out        = sdo_out_reg;
    assign sdo_oe         = sdo_oe_reg;
    assign sck_out        = sck_out_reg;
    assign sck_oe         = sck_oe_reg;
    assign conv_start     = conv_start_reg;
    assign conv_busy      = busy_reg;
    assign ext_sck_mode   = ext_mode_reg;
    assign ext_osc_active = ext_active_reg;

endmodule // adc_serial_readout_sequencer

`default_nettype wire

// >>> dv/adc_seq_checker.sv
`timescale 1ns/1ns
`default_nettype none

module adc_seq_checker #(
    parameter int CONV_CYC    = 200,
    parameter int EXT_DET_CYC = 20,
    parameter int OSC_CYC     = 4
) (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        reset_n,
    // Serial port
    input wire logic        cs_n,
    input wire logic        sck_in,
    input wire logic        sck_out,
    input wire logic        sck_oe,
    input wire logic        sdo_out,
    input wire logic        sdo_oe,
    // Source and result
    input wire logic        conv_clock_select_pin,
    input wire logic [15:0] result_data,
    input wire logic        result_sign,
    // Status
    input wire logic        conv_start,
    input wire logic        conv_busy,
    input wire logic        ext_sck_mode,
    input wire logic        ext_osc_active
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    int         busy_len_reg, busy_len_next;
    int         half_len_reg, half_len_next;
    logic       sck_q_reg, sck_q_next;
    logic [1:0] flips_reg, flips_next;
    logic       flip;

    // First half period after entry may be short, so two flips arm the check
    always_comb begin
        flip          = sck_out != sck_q_reg;
        sck_q_next    = sck_out;
        busy_len_next = conv_busy ? busy_len_reg + 1 : 0;
        half_len_next = flip ? 0 : half_len_reg + 1;
        // Re-armed per frame: the stretch held high through a conversion is no half period
        flips_next    = (!sck_oe || conv_busy) ? 2'h0
                      : (flip && flips_reg < 2'h2) ? flips_reg + 2'h1 : flips_reg;
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            busy_len_reg <= 0;
            half_len_reg <= 0;
            sck_q_reg    <= 1'b1;
            flips_reg    <= 2'h0;
        end else begin
            busy_len_reg <= busy_len_next;
            half_len_reg <= half_len_next;
            sck_q_reg    <= sck_q_next;
            flips_reg    <= flips_next;
        end
    end

    sdo_float_a: assert property (cs_n |=> !sdo_oe)
        else $error("data line driven with select high");
    sdo_drive_a: assert property (reset_n && !cs_n |=> sdo_oe)
        else $error("data line not driven with select low");
    busy_flag_a: assert property (sdo_oe && $past(sdo_oe) && conv_busy
        && $past(conv_busy) |-> sdo_out)
        else $error("flag low during conversion");
    start_busy_a: assert property (conv_start |-> conv_busy)
        else $error("start without conversion");
    start_pulse_a: assert property (conv_start |=> !conv_start)
        else $error("start pulse too long");
    sck_own_a: assert property (ext_sck_mode && $past(ext_sck_mode) |-> !sck_oe)
        else $error("clock driven in external mode");
    sck_div_a: assert property (sck_oe && flip && flips_reg == 2'h2 && !ext_osc_active
        |-> half_len_reg == 4 * OSC_CYC - 1)
        else $error("internal clock half period wrong");
    conv_len_a: assert property ($fell(conv_busy) && !ext_osc_active
        |-> busy_len_reg inside {[CONV_CYC - 1:CONV_CYC + 2]})
        else $error("conversion length wrong");
    mode_pick_a: assert property ($fell(cs_n) |=> ext_sck_mode == !$past(sck_in))
        else $error("clock mode not taken at select fall");
    mode_reset_a: assert property ($rose(reset_n) |=> ext_sck_mode == !$past(sck_in))
        else $error("clock mode not taken at reset end");

    cover property (conv_start);
    cover property ($fell(conv_busy) && ext_osc_active);
    cover property (sck_oe && flip);
endmodule // adc_seq_checker

bind adc_serial_readout_sequencer adc_seq_checker #(
    .CONV_CYC(CONV_CYC), .EXT_DET_CYC(EXT_DET_CYC), .OSC_CYC(OSC_CYC)
) adc_seq_checker_inst (
    .sys_clk(sys_clk), .reset_n(reset_n), .cs_n(cs_n), .sck_in(sck_in),
    .sck_out(sck_out), .sck_oe(sck_oe), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
    .conv_clock_select_pin(conv_clock_select_pin), .result_data(result_data),
    .result_sign(result_sign), .conv_start(conv_start), .conv_busy(conv_busy),
    .ext_sck_mode(ext_sck_mode), .ext_osc_active(ext_osc_active)
);

`default_nettype wire

// >>> dv/spi_host_model.sv
`timescale 1ns/1ns
`default_nettype none

module spi_host_model (
    // Clock
    input  wire logic        sys_clk,
    // Read request
    input  wire logic        go,
    input  wire logic [4:0]  nbits,
    input  wire logic        ext,
    // Wires
    input  wire logic        sck_line,
    input  wire logic        sdo_line,
    output logic             sck_host,
    // Captured bits, first bit ends up on top
    output logic [18:0]      frame,
    output logic             done
);
    int i;
    int w;
    logic s;

    initial begin
        sck_host = 1'b0;
        s = 1'b0;
        frame = 19'h0;
        done = 1'b0;
        forever begin
            @(posedge sys_clk);
            done <= 1'b0;
            if (go) begin
                for (i = 0; i < int'(nbits); i++) begin
                    if (ext) begin
                        // Idle level low keeps external mode at select fall
                        sck_host <= 1'b1;
                        frame <= {frame[17:0], sdo_line};
                        repeat (2) @(posedge sys_clk);
                        sck_host <= 1'b0;
                        repeat (2) @(posedge sys_clk);
                    end else begin
                        w = 0;
                        while (sck_line && w < 300) begin
                            @(posedge sys_clk);
                            w++;
                        end
                        // Keep the level from before the rise: the last rise also flips SDO
                        while (!sck_line && w < 300) begin
                            s = sdo_line;
                            @(posedge sys_clk);
                            w++;
                        end
                        frame <= {frame[17:0], s};
                    end
                end
                done <= 1'b1;
            end
        end
    end
endmodule // spi_host_model

`default_nettype wire

// >>> dv/tb_adc_serial_readout_sequencer.sv
`timescale 1ns/1ns
`default_nettype none

module tb_adc_serial_readout_sequencer;
    localparam int CONV = 200;
    logic        sys_clk = 1'b0, reset_n = 1'b0, cs_n = 1'b0, ext = 1'b1;
    logic        pin = 1'b0, pin_q = 1'b0, osc_on = 1'b0, go = 1'b0, sdo_q = 1'b0;
    logic [4:0]  nbits = 5'h13;
    logic [15:0] result_data = 16'h0;
    logic        result_sign = 1'b0;
    logic        sck_out, sck_oe, sdo_out, sdo_oe, conv_start, conv_busy;
    logic        ext_sck_mode, ext_osc_active, sck_host, done;
    logic [18:0] frame;
    logic [18:0] q[$];
    wire logic   sck_in, sdo_line;
    int          seed = 32'h133c;
    int          compares = 0, n_mismatch = 0, n_rise = 0;

    // Weak pull-up holds the clock wire high when nobody drives it
    assign sck_in = sck_oe ? sck_out : (ext ? sck_host : 1'b1);
    // A floating data line shows the inverse of its last driven level
    assign sdo_line = sdo_oe ? sdo_out : ~sdo_q;

    always #10 sys_clk = ~sys_clk;

    adc_serial_readout_sequencer #(.CONV_CYC(CONV), .EXT_DET_CYC(20), .OSC_CYC(4))
        adc_serial_readout_sequencer_inst (
        .sys_clk(sys_clk), .reset_n(reset_n), .cs_n(cs_n), .sck_in(sck_in),
        .sck_out(sck_out), .sck_oe(sck_oe), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
        .conv_clock_select_pin(pin), .result_data(result_data),
        .result_sign(result_sign), .conv_start(conv_start), .conv_busy(conv_busy),
        .ext_sck_mode(ext_sck_mode), .ext_osc_active(ext_osc_active));

    spi_host_model spi_host_model_inst (
        .sys_clk(sys_clk), .go(go), .nbits(nbits), .ext(ext), .sck_line(sck_in),
        .sdo_line(sdo_line), .sck_host(sck_host), .frame(frame), .done(done));

    always @(posedge sys_clk) begin
        if (sdo_oe) sdo_q <= sdo_out;
        if (osc_on) pin <= ~pin;
        pin_q <= pin;
        if (conv_start === 1'b1) n_rise <= 0;
        else if (conv_busy === 1'b1 && pin && !pin_q) n_rise <= n_rise + 1;
        if (done === 1'b1 && q.size() > 0) cmp_frame(frame, q.pop_front());
    end

    task automatic chk(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_frame(input logic [18:0] got, input logic [18:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic wait_idle;
        int k;
        for (k = 0; k < 60000 && conv_busy !== 1'b0; k++) @(posedge sys_clk);
        if (conv_busy !== 1'b0) n_mismatch++;
    endtask

    // Result inputs move mid-read; the frame must come from the held copy
    task automatic read(input logic [4:0] n);
        int k;
        @(posedge sys_clk);
        go <= 1'b1;
        nbits <= n;
        @(posedge sys_clk);
        go <= 1'b0;
        result_data <= 16'($random(seed));
        result_sign <= 1'($random(seed));
        for (k = 0; k < 2000 && done !== 1'b1; k++) @(posedge sys_clk);
        if (done !== 1'b1) n_mismatch++;
        @(posedge sys_clk);
    endtask

    task automatic expect_frame;
        q.push_back({1'b0, 1'b0, result_sign, result_data});
    endtask

    task automatic end_of_test;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    initial begin
        #(20 * 60000);
        n_mismatch++;
        end_of_test();
    end

    initial begin
        result_data <= 16'($random(seed));
        tick(3);
        reset_n <= 1'b1;
        tick(3);
        chk(ext_sck_mode, 1'b1);
        chk(sdo_out, 1'b1);
        chk(conv_busy, 1'b1);
        wait_idle();
        tick(2);
        chk(sdo_out, 1'b0);
        expect_frame();
        read(5'h13);
        tick(1);
        chk(sdo_out, 1'b1);
        chk(conv_busy, 1'b1);
        $display("test two_wire done");
        wait_idle();
        tick(2);
        read(5'h05);
        cs_n <= 1'b1;
        tick(3);
        chk(conv_busy, 1'b1);
        chk(sdo_oe, 1'b0);
        $display("test abort done");
        wait_idle();
        tick(2);
        chk(conv_busy, 1'b0);
        ext <= 1'b0;
        tick(1);
        cs_n <= 1'b0;
        tick(2);
        chk(ext_sck_mode, 1'b0);
        chk(sck_oe, 1'b1);
        expect_frame();
        read(5'h13);
        tick(2);
        chk(sdo_out, 1'b1);
        chk(conv_busy, 1'b1);
        $display("test internal_sck done");
        cs_n <= 1'b1;
        ext <= 1'b1;
        wait_idle();
        osc_on <= 1'b1;
        tick(5);
        chk(ext_osc_active, 1'b1);
        cs_n <= 1'b0;
        tick(2);
        chk(ext_sck_mode, 1'b1);
        expect_frame();
        read(5'h13);
        wait_idle();
        chk(n_rise >= 20509 && n_rise <= 20511, 1'b1);
        tick(2);
        expect_frame();
        read(5'h13);
        $display("test ext_clock done");
        end_of_test();
    end
endmodule // tb_adc_serial_readout_sequencer

`default_nettype wire
